// ### design/dbd_regs.vh
`ifndef DBD_REGS_VH
`define DBD_REGS_VH
// Register indexes on the plain register port.
`define DBD_ADDR_W 4
`define DBD_IDX_BASE0 4'h0
`define DBD_IDX_MASK0 4'h1
`define DBD_IDX_CTRL0 4'h2
`define DBD_IDX_BASE1 4'h3
`define DBD_IDX_MASK1 4'h4
`define DBD_IDX_CTRL1 4'h5
`define DBD_IDX_STAT 4'h6
`define DBD_IDX_IMSK 4'h7
// Mask register fields.
`define DBD_BAM_HI 31
`define DBD_BAM_LO 18
`define DBD_WP_BIT 8
`define DBD_AM_HI 6
`define DBD_AM_LO 1
`define DBD_V_BIT 0
`define DBD_MASK_WMASK 32'hfffc017f
`define DBD_MASK_RST 32'h00000000
// Control register fields.
`define DBD_RCD_BIT 0
`define DBD_EARLY_PRECHARGE_SELECT_BIT 1
`define DBD_CAS_HI 3
`define DBD_CAS_LO 2
`define DBD_SDRAM_BIT 4
`define DBD_CTRL_WMASK 32'h0000001f
`define DBD_CTRL_RST 32'h00000000
// Status bits.
`define DBD_ST_DONE 0
`define DBD_ST_WPERR 1
`define DBD_ST_MISS 2
`define DBD_ST_W 3
// Access type codes for mask bits 1..6; only those for bits 1 and 6 are defined.
`define DBD_AT_UD 3'h1
`define DBD_AT_CI 3'h6
`endif

// ### design/dbd_dram_block.v
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dbd_regs.vh"
module dbd_dram_block (
  // Clock, reset, enable.
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // Register port.
  input wire [`DBD_ADDR_W-1:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Internal bus request.
  input wire acc_start_in,
  input wire [31:0] acc_addr_in,
  input wire acc_write_in,
  input wire [2:0] acc_type_in,
  input wire [31:0] acc_wdata_in,
  output reg acc_done_out,
  output reg acc_miss_out,
  output reg acc_addr_exc_out,
  output reg [31:0] acc_rdata_out,
  // DRAM pins.
  output reg [25:0] dram_addr_out,
  output reg ras_n_out_0,
  output reg ras_n_out_1,
  output reg cas_n_out,
  output reg dram_we_n_out,
  output reg sdram_sel_out,
  input wire [31:0] dram_data_in,
  output reg [31:0] dram_data_out,
  output reg dram_data_oe_out,
  // Interrupt.
  output reg irq_out
);
  localparam S_IDLE = 5'h01;
  localparam S_ROW = 5'h02;
  localparam S_DLY = 5'h04;
  localparam S_CAS = 5'h08;
  localparam S_END = 5'h10;

  reg [31:0] base_ff [0:1];
  reg [31:0] mask_ff [0:1];
  reg [31:0] ctrl_ff [0:1];
  reg [3:0] stat_ff;
  reg [3:0] imsk_ff;
  reg [4:0] state_ff;
  reg blk_ff;
  reg [1:0] cnt_ff;
  reg [31:0] addr_ff;
  reg write_ff;
  reg [31:0] d_sync1_ff;
  reg [31:0] d_sync2_ff;
  reg ras_rise_ff;
  wire [1:0] hit;
  reg [3:0] ev;
  reg [31:0] rd_val;
  wire [1:0] cas_len;
  wire row_column_delay;
  wire early_precharge_select;
  integer i;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_hit
      assign hit[g] = mask_ff[g][`DBD_V_BIT] &
        ~mask_ff[g][acc_type_in] &
        (((acc_addr_in[31:18] ^ base_ff[g][31:18]) & ~mask_ff[g][`DBD_BAM_HI:`DBD_BAM_LO]) == 14'h0000);
    end
  endgenerate

  assign cas_len = ctrl_ff[blk_ff][`DBD_CAS_HI:`DBD_CAS_LO];
  assign row_column_delay = ctrl_ff[blk_ff][`DBD_RCD_BIT];
  assign early_precharge_select = ctrl_ff[blk_ff][`DBD_EARLY_PRECHARGE_SELECT_BIT];

  function [25:0] col_addr;
    input [31:0] a;
    begin
      col_addr = a[25:0];
      col_addr[15:9] = {a[2], a[3], a[4], a[5], a[6], a[7], a[8]};
      col_addr[17] = a[16];
      col_addr[19] = a[18];
      col_addr[21] = a[20];
      col_addr[23] = a[22];
      col_addr[25] = a[24];
    end
  endfunction

  always @* begin
    rd_val = 32'h00000000;
    case (reg_addr_in)
      `DBD_IDX_BASE0: rd_val = base_ff[0];
      `DBD_IDX_MASK0: rd_val = mask_ff[0];
      `DBD_IDX_CTRL0: rd_val = ctrl_ff[0];
      `DBD_IDX_BASE1: rd_val = base_ff[1];
      `DBD_IDX_MASK1: rd_val = mask_ff[1];
      `DBD_IDX_CTRL1: rd_val = ctrl_ff[1];
      `DBD_IDX_STAT: rd_val = {28'h0000000, stat_ff};
      `DBD_IDX_IMSK: rd_val = {28'h0000000, imsk_ff};
      default: rd_val = 32'h00000000;
    endcase
  end

  always @* begin
    ev = 4'h0;
    ev[`DBD_ST_DONE] = (state_ff == S_END);
    ev[`DBD_ST_WPERR] = (state_ff == S_IDLE) & acc_start_in & acc_write_in & (|(hit & {mask_ff[1][`DBD_WP_BIT],
      mask_ff[0][`DBD_WP_BIT]}));
    ev[`DBD_ST_MISS] = (state_ff == S_IDLE) & acc_start_in & ~(|hit);
  end

  // Data pins come from another timing domain, so two stages precede capture.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      d_sync1_ff <= 32'h00000000;
      d_sync2_ff <= 32'h00000000;
    end else if (ce_in) begin
      d_sync1_ff <= dram_data_in;
      d_sync2_ff <= d_sync1_ff;
    end
  end

  // row strobe drops at the rising edge after the address; this falling-edge flag drives no pin.
  always @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ras_rise_ff <= 1'b0;
    end else if (ce_in) begin
      ras_rise_ff <= (state_ff == S_ROW);
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (i = 0; i < 2; i = i + 1) begin
        base_ff[i] <= 32'h00000000;
        mask_ff[i] <= `DBD_MASK_RST;
        ctrl_ff[i] <= `DBD_CTRL_RST;
      end
      stat_ff <= 4'h0;
      imsk_ff <= 4'h0;
      state_ff <= S_IDLE;
      blk_ff <= 1'b0;
      cnt_ff <= 2'h0;
      addr_ff <= 32'h00000000;
      write_ff <= 1'b0;
      reg_rdata_out <= 32'h00000000;
      acc_done_out <= 1'b0;
      acc_miss_out <= 1'b0;
      acc_addr_exc_out <= 1'b0;
      acc_rdata_out <= 32'h00000000;
      dram_addr_out <= 26'h0000000;
      ras_n_out_0 <= 1'b1;
      ras_n_out_1 <= 1'b1;
      cas_n_out <= 1'b1;
      dram_we_n_out <= 1'b1;
      sdram_sel_out <= 1'b0;
      dram_data_out <= 32'h00000000;
      dram_data_oe_out <= 1'b0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      reg_rdata_out <= reg_rd_in ? rd_val : 32'h00000000;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `DBD_IDX_BASE0: base_ff[0] <= reg_wdata_in & 32'hfffc0000;
          `DBD_IDX_MASK0: mask_ff[0] <= reg_wdata_in & `DBD_MASK_WMASK;
          `DBD_IDX_CTRL0: ctrl_ff[0] <= reg_wdata_in & `DBD_CTRL_WMASK;
          `DBD_IDX_BASE1: base_ff[1] <= reg_wdata_in & 32'hfffc0000;
          `DBD_IDX_MASK1: mask_ff[1] <= reg_wdata_in & `DBD_MASK_WMASK;
          `DBD_IDX_CTRL1: ctrl_ff[1] <= reg_wdata_in & `DBD_CTRL_WMASK;
          `DBD_IDX_IMSK: imsk_ff <= reg_wdata_in[3:0];
          default: ;
        endcase
      end
      // A new event wins over a write-one clear in the same cycle.
      stat_ff <= (stat_ff & ~((reg_wr_in && reg_addr_in == `DBD_IDX_STAT) ? reg_wdata_in[3:0] : 4'h0)) | ev;
      irq_out <= |(stat_ff & imsk_ff);
      acc_done_out <= 1'b0;
      acc_miss_out <= 1'b0;
      acc_addr_exc_out <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (acc_start_in) begin
            if (|hit) begin
              blk_ff <= hit[1] & ~hit[0];
              if (acc_write_in & mask_ff[hit[0] ? 0 : 1][`DBD_WP_BIT]) begin
                acc_addr_exc_out <= 1'b1;
                acc_miss_out <= 1'b1;
              end else begin
                addr_ff <= acc_addr_in;
                write_ff <= acc_write_in;
                dram_addr_out <= acc_addr_in[25:0];
                dram_we_n_out <= ~acc_write_in;
                dram_data_out <= acc_wdata_in;
                dram_data_oe_out <= acc_write_in;
                sdram_sel_out <= ctrl_ff[hit[0] ? 0 : 1][`DBD_SDRAM_BIT];
                state_ff <= S_ROW;
              end
            end else begin
              acc_miss_out <= 1'b1;
            end
          end
        end
        S_ROW: begin
          if (blk_ff) ras_n_out_1 <= 1'b0;
          else ras_n_out_0 <= 1'b0;
          if (row_column_delay) begin
            state_ff <= S_DLY;
          end else begin
            dram_addr_out <= col_addr(addr_ff);
            state_ff <= S_CAS;
          end
          cnt_ff <= cas_len;
        end
        S_DLY: begin
          dram_addr_out <= col_addr(addr_ff);
          state_ff <= S_CAS;
        end
        S_CAS: begin
          cas_n_out <= 1'b0;
          if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1;
          end else begin
            if (early_precharge_select) begin
              ras_n_out_0 <= 1'b1;
              ras_n_out_1 <= 1'b1;
            end
            state_ff <= S_END;
          end
        end
        S_END: begin
          // capture on last edge.
          // The two pin stages delay the bus, so with a CAS field of 2 or 3 the word seen here was sampled while the strobe was low.
          if (!write_ff) acc_rdata_out <= d_sync2_ff;
          cas_n_out <= 1'b1;
          ras_n_out_0 <= 1'b1;
          ras_n_out_1 <= 1'b1;
          dram_data_oe_out <= 1'b0;
          dram_we_n_out <= 1'b1;
          acc_done_out <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // dbd_dram_block
`default_nettype wire

// ### sim/dbd_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbd_dram_model #(
  parameter logic [31:0] RD_PATTERN = 32'h5a3c0f96
) (
  // Memory pins.
  input wire logic cas_n_in,
  output logic [31:0] data_out
);
  // data while strobed
  // Outside the strobe the bus shows the inverse, so stale data can never pass.
  assign data_out = cas_n_in ? ~RD_PATTERN : RD_PATTERN;
endmodule // dbd_dram_model
`default_nettype wire

// ### sim/dbd_dram_block_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dbd_dram_block_props (
  // Clock and reset.
  input wire clk_in,
  input wire rst_in,
  // Watched ports.
  input wire acc_start_in,
  input wire [31:0] acc_addr_in,
  input wire acc_write_in,
  input wire [31:0] acc_wdata_in,
  input wire acc_done_out,
  input wire acc_miss_out,
  input wire acc_addr_exc_out,
  input wire [25:0] dram_addr_out,
  input wire ras_n_out_0,
  input wire cas_n_out,
  input wire dram_we_n_out,
  input wire [31:0] dram_data_out,
  input wire dram_data_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire [6:0] col_lo = {acc_addr_in[2], acc_addr_in[3], acc_addr_in[4], acc_addr_in[5], acc_addr_in[6],
    acc_addr_in[7], acc_addr_in[8]};
  wire [4:0] col_hi = {acc_addr_in[24], acc_addr_in[22], acc_addr_in[20], acc_addr_in[18], acc_addr_in[16]};
  wire [4:0] pin_hi = {dram_addr_out[25], dram_addr_out[23], dram_addr_out[21], dram_addr_out[19], dram_addr_out[17]};
  sequence s_cas_on; $fell(cas_n_out); endsequence
  sequence s_cas_off; $rose(cas_n_out); endsequence
  property p_row; $fell(ras_n_out_0) |-> $past(dram_addr_out[25:9]) == $past(acc_addr_in[25:9]); endproperty
  a_row: assert property (p_row) else $error("row address wrong");
  property p_col_lo; s_cas_on |-> dram_addr_out[15:9] == col_lo; endproperty
  a_col_lo: assert property (p_col_lo) else $error("low column address wrong");
  property p_col_hi; s_cas_on |-> pin_hi == col_hi; endproperty
  a_col_hi: assert property (p_col_hi) else $error("high column address wrong");
  property p_ras_lead; $fell(ras_n_out_0) |-> $past(acc_start_in, 2); endproperty
  a_ras_lead: assert property (p_ras_lead) else $error("row strobe not two cycles after start");
  property p_cas_lead; s_cas_on |-> $past(!ras_n_out_0); endproperty
  a_cas_lead: assert property (p_cas_lead) else $error("column strobe without row strobe");
  property p_done; s_cas_off |-> acc_done_out; endproperty
  a_done: assert property (p_done) else $error("no done at end of transfer");
  property p_prech; s_cas_off |-> $past(ras_n_out_0) && !$past(ras_n_out_0, 2); endproperty
  a_prech: assert property (p_prech) else $error("precharge not one clock early");
  property p_wdata; !cas_n_out && acc_write_in |-> !dram_we_n_out && dram_data_oe_out && dram_data_out == acc_wdata_in;
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not driven");
  property p_miss; acc_miss_out |-> $past(acc_start_in) && ras_n_out_0; endproperty
  a_miss: assert property (p_miss) else $error("miss timing wrong");
  property p_exc; acc_addr_exc_out |-> acc_miss_out && acc_write_in; endproperty
  a_exc: assert property (p_exc) else $error("exception without protected write");
endmodule // dbd_dram_block_props
bind dbd_dram_block dbd_dram_block_props dbd_dram_block_props_inst (.clk_in, .rst_in, .acc_start_in, .acc_addr_in,
  .acc_write_in, .acc_wdata_in, .acc_done_out, .acc_miss_out, .acc_addr_exc_out, .dram_addr_out, .ras_n_out_0,
  .cas_n_out, .dram_we_n_out, .dram_data_out, .dram_data_oe_out);
`default_nettype wire

// ### sim/dbd_dram_block_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbd_regs.vh"
module dbd_dram_block_bench;
  localparam logic [31:0] RD_PATTERN = 32'h5a3c0f96;
  logic clk_in = 0;
  logic rst_in = 1;
  logic [3:0] reg_addr_in = 0;
  logic [31:0] reg_wdata_in = 0;
  logic reg_wr_in = 0;
  logic reg_rd_in = 0;
  logic acc_start_in = 0;
  logic [31:0] acc_addr_in = 0;
  logic acc_write_in = 0;
  logic [2:0] acc_type_in = 1;
  logic [31:0] acc_wdata_in = 0;
  wire [31:0] reg_rdata_out, acc_rdata_out, dram_data_in, dram_data_out;
  wire acc_done_out, acc_miss_out, acc_addr_exc_out, ras_n_out_0, ras_n_out_1, cas_n_out, dram_we_n_out;
  wire sdram_sel_out, dram_data_oe_out, irq_out;
  wire [25:0] dram_addr_out;
  int fails = 0;
  int cmp_count = 0;
  int i;
  dbd_dram_block dbd_dram_block_inst (.clk_in, .rst_in, .ce_in(1'b1), .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .acc_start_in, .acc_addr_in, .acc_write_in, .acc_type_in, .acc_wdata_in,
    .acc_done_out, .acc_miss_out, .acc_addr_exc_out, .acc_rdata_out, .dram_addr_out, .ras_n_out_0, .ras_n_out_1,
    .cas_n_out, .dram_we_n_out, .sdram_sel_out, .dram_data_in, .dram_data_out, .dram_data_oe_out, .irq_out);
  dbd_dram_model #(.RD_PATTERN(RD_PATTERN)) dbd_dram_model_inst (.cas_n_in(cas_n_out), .data_out(dram_data_in));
  always #20 clk_in = ~clk_in;
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1;
    @(posedge clk_in);
    reg_wr_in <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1;
    @(posedge clk_in);
    reg_rd_in <= 0;
    #1 chk("register", reg_rdata_out, e);
  endtask
  // Expected result is {done, miss, address exception}.
  task automatic acc(input logic [31:0] a, input logic w, input logic [2:0] t, input logic [2:0] e);
    @(posedge clk_in);
    acc_start_in <= 1;
    acc_addr_in <= a;
    acc_write_in <= w;
    acc_type_in <= t;
    acc_wdata_in <= ~a;
    @(posedge clk_in);
    acc_start_in <= 0;
    #1;
    for (i = 0; i < 40 && acc_done_out !== 1 && acc_miss_out !== 1; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (i == 40) begin
      fails++;
      wrap_up();
    end
    chk("access result", {29'h0, acc_done_out, acc_miss_out, acc_addr_exc_out}, {29'h0, e});
    if (e[2] && !w) chk("read data", acc_rdata_out, RD_PATTERN);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 0;
    rd(`DBD_IDX_MASK0, 0);
    rd(4'hf, 0);
    acc(32'h00400000, 0, 1, 3'b010);
    $display("test reset done");
    wr(`DBD_IDX_BASE0, 32'h00400000);
    wr(`DBD_IDX_CTRL0, 32'h0000000a);
    wr(`DBD_IDX_MASK0, 32'h000c0001);
    acc(32'h004dab7c, 0, 1, 3'b100);
    acc(32'h00500124, 0, 1, 3'b010);
    acc(32'h0045a5a8, 1, 2, 3'b100);
    $display("test decode done");
    for (int t = 1; t <= 6; t++) begin
      wr(`DBD_IDX_MASK0, 32'h00000001 | (32'h1 << t));
      acc(32'h00400010, 0, 3'(t), 3'b010);
      acc(32'h00400010, 0, 3'(t % 6 + 1), 3'b100);
    end
    $display("test access types done");
    wr(`DBD_IDX_MASK0, 32'h00000101);
    acc(32'h00400020, 1, 1, 3'b011);
    acc(32'h00400020, 0, 1, 3'b100);
    $display("test write protect done");
    rd(`DBD_IDX_STAT, 32'h7);
    chk("irq", {31'h0, irq_out}, 0);
    wr(`DBD_IDX_IMSK, 32'h7);
    @(posedge clk_in);
    #1 chk("irq", {31'h0, irq_out}, 1);
    wr(`DBD_IDX_IMSK, 0);
    wr(`DBD_IDX_STAT, 32'h7);
    rd(`DBD_IDX_STAT, 0);
    chk("irq", {31'h0, irq_out}, 0);
    $display("test interrupt done");
    wrap_up();
  end
endmodule // dbd_dram_block_bench
`default_nettype wire
